/* rtl/shc_handler_ctl.sv */
// Purpose: handler control and state register with fault escalation
// Assumes: classic Wishbone master on clk_i, core strobes on clk_i
// Notes:   answers one cycle after a request; err for bad address or mode
`timescale 1ns/100ps
module shc_handler_ctl
   import shc_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [SHC_ADR_W-1:0] adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   output logic                      err_o,
   // core mode
   input  wire logic                 priv_i,
   // core exception events
   input  wire shc_status_t          hw_set_i,
   input  wire shc_status_t          hw_clr_i,
   input  wire shc_fault_t           fault_i,
   input  wire logic                 bus_fault_en_i,
   input  wire logic                 usage_fault_en_i,
   // state toward the core
   output shc_status_t               status_o,
   output logic                      prot_fault_en_o,
   output logic                      hard_fault_o
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic        ack_r;
   logic        ack_nxt;
   logic        err_r;
   logic        err_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic        en_r;
   logic        en_nxt;
   logic        hf_r;
   logic        hf_nxt;
   logic        req_new;
   logic        hit;
   logic        wr_go;
   logic [31:0] rd_word;
   shc_status_t flags;
   shc_status_t set_all;
   shc_status_t wr_bit;
   shc_status_t wr_val;
   shc_fault_t  fault_en;
   shc_fault_t  fault_esc;

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   // only the word address matters; byte lanes select the fields
   assign hit     = (adr_i[SHC_ADR_W-1:2] == SHC_REG_OFS[SHC_ADR_W-1:2]);
   // a new request is one not yet answered
   assign req_new = cyc_i & stb_i & ~ack_r & ~err_r;
   // write lands on the edge where the master sees ack
   assign wr_go   = ack_r & cyc_i & stb_i & we_i;

   // answer selection: ack only for a privileged hit
   always_comb begin
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      if (req_new) begin
         if (hit && priv_i) begin
            ack_nxt = 1'b1;
         end else begin
            err_nxt = 1'b1;
         end
      end
   end

   // answer register; drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         err_r <= err_nxt;
      end
   end

   // -------------------------------------------------------------
   // fault escalation
   // -------------------------------------------------------------
   // bus and usage enables live beside this register in the core
   assign fault_en.usage = usage_fault_en_i;
   assign fault_en.bus   = bus_fault_en_i;
   assign fault_en.prot  = en_r;

   // a disabled fault becomes a hard fault and is not pended
   assign fault_esc = fault_i & ~fault_en;

   // hard fault pulse, one cycle per escalated fault cycle
   always_comb begin
      hf_nxt = |fault_esc;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hf_r <= 1'b0;
      end else begin
         hf_r <= hf_nxt;
      end
   end

   // -------------------------------------------------------------
   // hardware set sources
   // -------------------------------------------------------------
   // enabled faults pend their own exception
   always_comb begin
      set_all            = hw_set_i;
      set_all.usage_pend = hw_set_i.usage_pend | (fault_i.usage & fault_en.usage);
      set_all.bus_pend   = hw_set_i.bus_pend | (fault_i.bus & fault_en.bus);
      set_all.prot_pend  = hw_set_i.prot_pend | (fault_i.prot & fault_en.prot);
   end

   // -------------------------------------------------------------
   // software write per flag, by byte lane
   // -------------------------------------------------------------
   // reserved positions are never picked up, so writes to them vanish
   always_comb begin
      wr_bit = '0;
      wr_val = '0;
      for (int i = 0; i < SHC_NFLAG; i++) begin
         wr_bit[i] = wr_go & sel_i[SHC_FLAG_POS[i] / 8];
         wr_val[i] = dat_i[SHC_FLAG_POS[i]];
      end
   end

   // -------------------------------------------------------------
   // status flags
   // -------------------------------------------------------------
   // pending bits 15-12 and active bits 11-10, 8, 7, 3, 1, 0
   generate
      for (genvar g = 0; g < SHC_NFLAG; g++) begin : g_flag
         shc_flag_cell u_cell (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .set_i   (set_all[g]),
            .clr_i   (hw_clr_i[g]),
            .wr_i    (wr_bit[g]),
            .wdata_i (wr_val[g]),
            .flag_o  (flags[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------
   // protection fault enable
   // -------------------------------------------------------------
   // lane 2 carries bit 16
   always_comb begin
      en_nxt = en_r;
      if (wr_go && sel_i[SHC_PROT_EN_BIT / 8]) begin
         en_nxt = dat_i[SHC_PROT_EN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r <= SHC_PROT_EN_RST;
      end else begin
         en_r <= en_nxt;
      end
   end

   // -------------------------------------------------------------
   // read data
   // -------------------------------------------------------------
   // reserved bits stay zero in the packed word
   assign rd_word = shc_pack(flags, en_r);

   // captured on the accepting edge; zero for errors and writes
   always_comb begin
      dat_nxt = 32'h0000_0000;
      if (req_new && hit && priv_i && !we_i) begin
         dat_nxt = rd_word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else begin
         dat_r <= dat_nxt;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign ack_o           = ack_r;
   assign err_o           = err_r;
   assign dat_o           = dat_r;
   assign status_o        = flags;
   assign prot_fault_en_o = en_r;
   assign hard_fault_o    = hf_r;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // request as seen on the bus
   sequence s_priv_req;
      cyc_i && stb_i && !ack_o && !err_o && priv_i && hit;
   endsequence

   sequence s_user_req;
      cyc_i && stb_i && !ack_o && !err_o && !priv_i;
   endsequence

   // any answer lasts one cycle
   AST_ANSWER_PULSE: assert property (
      (ack_o || err_o) |=> !ack_o && !err_o
   ) else $error("answer held longer than one cycle");

   // privileged hit answered next cycle with ack
   AST_PRIV_ACK: assert property (
      s_priv_req |=> ack_o && !err_o
   ) else $error("privileged access not acknowledged");

   // user-mode write refused and register untouched
   // core strobes must stay quiet over both cycles, or a legal set would look like a leak
   AST_USER_ERR: assert property (
      s_user_req ##0 (we_i && fault_i == '0 && hw_set_i == '0 && hw_clr_i == '0)
      ##1 (fault_i == '0 && hw_set_i == '0 && hw_clr_i == '0)
      |-> err_o && !ack_o ##1 (status_o == $past(status_o, 2)
                               && prot_fault_en_o == $past(prot_fault_en_o, 2))
   ) else $error("user-mode access was not refused");

   // enable follows a lane-2 write
   AST_EN_WRITE: assert property (
      ack_o && we_i && cyc_i && stb_i && sel_i[2]
      |=> prot_fault_en_o == $past(dat_i[16])
   ) else $error("protection fault enable did not take write");

   // reserved bits read back as zero on every acknowledged answer
   AST_RESERVED_ZERO: assert property (
      ack_o |-> (dat_o & ~SHC_IMPL_MASK) == 32'h0000_0000
   ) else $error("reserved bit read as one");

   // read data reflects state at accept
   AST_READ_DATA: assert property (
      s_priv_req ##0 !we_i |=> ack_o && dat_o == $past(rd_word)
   ) else $error("read data does not match register state");

   // disabled protection fault escalates, not pends
   AST_ESCALATE: assert property (
      fault_i.prot && !prot_fault_en_o && !hw_set_i.prot_pend
      && !(wr_go && sel_i[1])
      |=> hard_fault_o && ($past(status_o.prot_pend) == status_o.prot_pend
                           || !status_o.prot_pend)
   ) else $error("disabled fault not escalated");

   // enabled fault pends without escalation
   AST_PEND_ON_FAULT: assert property (
      fault_i.prot && prot_fault_en_o && (!fault_i.bus || bus_fault_en_i)
      && (!fault_i.usage || usage_fault_en_i)
      |=> status_o.prot_pend && !hard_fault_o
   ) else $error("enabled fault did not pend");

   // no escalation without a fault
   AST_NO_SPURIOUS_HF: assert property (
      fault_i == '0 |=> !hard_fault_o
   ) else $error("hard fault without cause");

   // unmapped word refused whatever the mode
   sequence s_miss_req;
      cyc_i && stb_i && !ack_o && !err_o && !hit;
   endsequence

   AST_MISS_ERR: assert property (
      s_miss_req |=> err_o && !ack_o && dat_o == 32'h0000_0000
   ) else $error("unmapped access not refused");

   // refused read returns no register content
   AST_USER_RD_ZERO: assert property (
      s_user_req ##0 !we_i |=> err_o && dat_o == 32'h0000_0000
   ) else $error("user-mode read returned data");

   // write answers carry no data
   AST_WRITE_NO_DATA: assert property (
      s_priv_req ##0 we_i |=> ack_o && dat_o == 32'h0000_0000
   ) else $error("write answer carried data");

   // enable moves only on an acknowledged lane-2 write
   AST_EN_HOLD: assert property (
      !(wr_go && sel_i[2]) |=> $stable(prot_fault_en_o)
   ) else $error("protection fault enable changed without write");

   // disabled bus or usage fault reaches the hard fault output
   AST_ANY_ESCALATE: assert property (
      (fault_i.bus && !bus_fault_en_i) || (fault_i.usage && !usage_fault_en_i)
      |=> hard_fault_o
   ) else $error("disabled bus or usage fault not escalated");

   // enabled bus fault pends its own flag
   AST_BUS_PEND: assert property (
      fault_i.bus && bus_fault_en_i |=> status_o.bus_pend
   ) else $error("enabled bus fault did not pend");

   // enabled usage fault pends its own flag
   AST_USAGE_PEND: assert property (
      fault_i.usage && usage_fault_en_i |=> status_o.usage_pend
   ) else $error("enabled usage fault did not pend");

   // per flag: write takes value, hardware set always wins
   generate
      for (genvar a = 0; a < SHC_NFLAG; a++) begin : g_chk
         AST_FLAG_WRITE: assert property (
            wr_bit[a] && !set_all[a]
            |=> status_o[a] == $past(dat_i[SHC_FLAG_POS[a]])
         ) else $error("flag did not take written value");

         AST_SET_WINS: assert property (
            set_all[a] |=> status_o[a] ##1 (status_o[a] || $past(hw_clr_i[a])
                                            || $past(wr_bit[a]))
         ) else $error("hardware set was lost");

         AST_FLAG_HOLD: assert property (
            !set_all[a] && !hw_clr_i[a] && !wr_bit[a] |=> $stable(status_o[a])
         ) else $error("flag changed without cause");

         AST_CLEAR_WORKS: assert property (
            hw_clr_i[a] && !set_all[a] && !wr_bit[a] |=> !status_o[a]
         ) else $error("hardware clear was lost");
      end
   endgenerate

endmodule

/* rtl/shc_pkg.sv */
// Purpose: constants and carriers for the handler control and state register
// Assumes: one 32-bit Wishbone slave word on the core clock
// Notes:   field positions are fixed by the register layout
package shc_pkg;

   // -------------------------------------------------------------
   // address map
   // -------------------------------------------------------------
   localparam int          SHC_ADR_W   = 12;
   localparam logic [11:0] SHC_REG_OFS = 12'hD24;

   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int          SHC_PROT_EN_BIT = 16;
   localparam logic        SHC_PROT_EN_RST = 1'h0;
   localparam logic [10:0] SHC_FLAG_RST    = 11'h000;
   localparam int          SHC_NFLAG       = 11;
   // word position of each flag, index 0 = protection fault active
   localparam int SHC_FLAG_POS [SHC_NFLAG] = '{0, 1, 3, 7, 8, 10, 11, 12, 13, 14, 15};
   // implemented bits: 16, 15-10, 8, 7, 3, 1, 0
   localparam logic [31:0] SHC_IMPL_MASK = 32'h0001_FD8B;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic svc_pend;
      logic bus_pend;
      logic prot_pend;
      logic usage_pend;
      logic tick_act;
      logic defer_act;
      logic watch_act;
      logic svc_act;
      logic usage_act;
      logic bus_act;
      logic prot_act;
   } shc_status_t;

   typedef struct packed {
      logic usage;
      logic bus;
      logic prot;
   } shc_fault_t;

   // flags to register word, reserved bits left zero
   function automatic logic [31:0] shc_pack(input shc_status_t s, input logic en);
      logic [31:0] w;
      w = 32'h0000_0000;
      for (int i = 0; i < SHC_NFLAG; i++) begin
         w[SHC_FLAG_POS[i]] = s[i];
      end
      w[SHC_PROT_EN_BIT] = en;
      return w;
   endfunction

endpackage

/* rtl/shc_flag_cell.sv */
// Purpose: one hardware and software writable status flag
// Assumes: set, clear and write are single-cycle strobes on clk_i
// Notes:   hardware set wins over a software write and a hardware clear
`timescale 1ns/100ps
module shc_flag_cell
   import shc_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // hardware side
   input  wire logic set_i,
   input  wire logic clr_i,
   // software side
   input  wire logic wr_i,
   input  wire logic wdata_i,
   // state
   output logic      flag_o
);

   logic flag_r;
   logic flag_nxt;

   // -------------------------------------------------------------
   // next value: set first so no event is lost
   // -------------------------------------------------------------
   always_comb begin
      flag_nxt = flag_r;
      if (set_i) begin
         flag_nxt = 1'b1;
      end else if (wr_i) begin
         flag_nxt = wdata_i;
      end else if (clr_i) begin
         flag_nxt = 1'b0;
      end
   end

   // register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;

endmodule

/* tb/shc_handler_ctl_tb.sv */
// Purpose: self-checking bench for the handler control and state register
// Assumes: classic Wishbone single cycles; core strobes one cycle wide
// Notes:   expected words follow the documented bit layout, not the design
`timescale 1ns/100ps
module shc_handler_ctl_tb
   import shc_pkg::*;
();
   // ----------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------
   localparam logic [11:0] ADR  = 12'hD24;
   localparam logic [31:0] IMPL = 32'h0001_FD8B;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic        priv_i = 1'b1;
   shc_status_t hw_set_i = '0;
   shc_status_t hw_clr_i = '0;
   shc_fault_t  fault_i = '0;
   logic        bus_fault_en_i = 1'b0;
   logic        usage_fault_en_i = 1'b0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        err_o;
   shc_status_t status_o;
   logic        prot_fault_en_o;
   logic        hard_fault_o;
   int          fail_count = 0;
   int          check_count = 0;
   logic [31:0] q;
   logic        e;
   int          bits [12] = '{0, 1, 3, 7, 8, 10, 11, 12, 13, 14, 15, 16};
   int          pend [3] = '{13, 14, 12};

   always #50 clk_i = ~clk_i;

   shc_handler_ctl shc_handler_ctl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .priv_i(priv_i),
      .hw_set_i(hw_set_i), .hw_clr_i(hw_clr_i), .fault_i(fault_i), .bus_fault_en_i(bus_fault_en_i),
      .usage_fault_en_i(usage_fault_en_i), .status_o(status_o), .prot_fault_en_o(prot_fault_en_o),
      .hard_fault_o(hard_fault_o));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic tally_and_finish;
      $display("TB: checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // four-state compare so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; bounded wait so a silent slave cannot hang us
   task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d,
                     input logic p, output logic [31:0] rq, output logic re);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i  <= 1'b1;
      stb_i  <= 1'b1;
      we_i   <= w;
      adr_i  <= a;
      sel_i  <= s;
      dat_i  <= d;
      priv_i <= p;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("Error at %0t: bus answer timed out", $time);
         tally_and_finish();
      end else begin
         rq = dat_o;
         re = err_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i  <= 1'b0;
      end
   endtask

   // access with expected error flag, read data checked on reads
   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d,
                      input logic p, input logic [31:0] exp, input logic experr);
      wb(w, a, s, d, p, q, e);
      chk({31'h0, e}, {31'h0, experr});
      if (!w) begin
         chk(q, exp);
      end
   endtask

   // one-cycle core strobes, then one edge for the flags to land
   task automatic ev(input shc_status_t st, input shc_status_t cl, input shc_fault_t f);
      @(posedge clk_i);
      hw_set_i <= st;
      hw_clr_i <= cl;
      fault_i  <= f;
      @(posedge clk_i);
      hw_set_i <= '0;
      hw_clr_i <= '0;
      fault_i  <= '0;
      @(posedge clk_i);
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({20'h0, status_o, prot_fault_en_o}, 32'h0);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0, 0);
      // each field alone, word and core-side view together
      foreach (bits[i]) begin
         acc(1, ADR, 4'hF, 32'h1 << bits[i], 1, 32'h0, 0);
         acc(0, ADR, 4'hF, 32'h0, 1, 32'h1 << bits[i], 0);
         chk({20'h0, prot_fault_en_o, status_o}, (32'h1 << i));
      end
      acc(1, ADR, 4'hF, 32'hFFFF_FFFF, 1, 32'h0, 0);
      acc(0, ADR, 4'hF, 32'h0, 1, IMPL, 0);
      acc(1, ADR, 4'hF, 32'h0, 1, 32'h0, 0);
      // byte lanes gate their own fields only
      acc(1, ADR, 4'h1, 32'hFFFF_FFFF, 1, 32'h0, 0);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0000_008B, 0);
      acc(1, ADR, 4'h6, 32'hFFFF_FFFF, 1, 32'h0, 0);
      acc(0, ADR, 4'hF, 32'h0, 1, IMPL, 0);
      // refused accesses leave the word untouched
      acc(1, ADR, 4'hF, 32'h0, 0, 32'h0, 1);
      acc(0, ADR, 4'hF, 32'h0, 0, 32'h0, 1);
      acc(1, 12'hD20, 4'hF, 32'h0, 1, 32'h0, 1);
      acc(0, 12'hD28, 4'hF, 32'h0, 1, 32'h0, 1);
      acc(0, ADR, 4'hF, 32'h0, 1, IMPL, 0);
      // single-bit change by read-modify-write keeps the rest
      acc(1, ADR, 4'hF, 32'h0000_0083, 1, 32'h0, 0);
      wb(0, ADR, 4'hF, 32'h0, 1, q, e);
      wb(1, ADR, 4'hF, q | 32'h0000_0100, 1, q, e);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0000_0183, 0);
      // core set and clear strobes reach the word
      ev(shc_status_t'(11'h7FF), '0, '0);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0000_FD8B, 0);
      // set and clear in one cycle: the set must win
      ev(shc_status_t'(11'h7FF), shc_status_t'(11'h7FF), '0);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0000_FD8B, 0);
      ev('0, shc_status_t'(11'h7FF), '0);
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0, 0);
      // disabled faults escalate, enabled ones go pending
      for (int k = 0; k < 3; k++) begin
         ev('0, '0, shc_fault_t'(3'h1 << k));
         chk({31'h0, hard_fault_o}, 32'h1);
      end
      acc(0, ADR, 4'hF, 32'h0, 1, 32'h0, 0);
      acc(1, ADR, 4'hF, 32'h0001_0000, 1, 32'h0, 0);
      bus_fault_en_i   <= 1'b1;
      usage_fault_en_i <= 1'b1;
      q = 32'h0001_0000;
      for (int k = 0; k < 3; k++) begin
         ev('0, '0, shc_fault_t'(3'h1 << k));
         chk({31'h0, hard_fault_o}, 32'h0);
         q = q | (32'h1 << pend[k]);
         acc(0, ADR, 4'hF, 32'h0, 1, q, 0);
      end
      tally_and_finish();
   end
endmodule
